// >>> shared/sfcr_pkg.sv
// Purpose: Shared constants and types for the serial flash configuration registers
// Assumes: Link is SPI mode 0, commands and addresses sent one bit wide
// Notes:   Register byte addresses used by the read-any and write-any commands
package sfcr_pkg;

  // ------------------------------------------------------------
  // Command opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_READ_CONFIG_ONE = 8'h35;
  localparam logic [7:0] CMD_READ_ANY_REG = 8'h65;
  localparam logic [7:0] CMD_WRITE_ANY_REG = 8'h71;
  localparam logic [7:0] CMD_WRITE_REGS = 8'h01;
  localparam logic [7:0] CMD_NV_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_VOLATILE_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] CMD_NIBBLE_CMD_ENTER = 8'h38;
  localparam logic [7:0] CMD_NIBBLE_CMD_EXIT = 8'hF5;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h99;

  // ------------------------------------------------------------
  // Register addresses for read-any and write-any
  // ------------------------------------------------------------
  localparam logic [23:0] ADDR_VOLATILE_CONFIG_ONE = 24'h800002;
  localparam logic [23:0] ADDR_NONVOLATILE_CONFIG_TWO = 24'h000003;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CFG1_HALT_BIT = 7;
  localparam int CFG1_INVERT_BIT = 6;
  localparam int CFG1_WIDE_BIT = 1;
  localparam int CFG1_FREEZE_BIT = 0;
  localparam int CFG2_LINE3_RESET_BIT = 7;
  localparam int CFG2_DRIVE_HI_BIT = 6;
  localparam int CFG2_DRIVE_LO_BIT = 5;
  localparam int CFG2_NIBBLE_BIT = 3;
  localparam int CFG2_PROTECT_BIT = 2;
  localparam int CFG2_ADDR_LEN_BIT = 1;

  // ------------------------------------------------------------
  // Reset values and masks
  // ------------------------------------------------------------
  localparam logic [7:0] CFG2_NV_RESET = 8'h60;
  localparam logic [7:0] CFG2_WRITE_MASK = 8'hEE;

  // ------------------------------------------------------------
  // Link bit counts (count of rising clocks in the frame)
  // ------------------------------------------------------------
  localparam logic [5:0] BIT_CMD_LAST = 6'h07;
  localparam logic [5:0] BIT_READ_ONE_OUT = 6'h08;
  localparam logic [5:0] BIT_WRITE_REGS_LAST = 6'h17;
  localparam logic [5:0] BIT_READ_ANY_OUT = 6'h20;
  localparam logic [5:0] BIT_WRITE_ANY_LAST = 6'h27;
  localparam logic [5:0] BIT_SATURATE = 6'h28;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int WIDE_ENTER_TIME_NS = 20;
  localparam int WIDE_EXIT_TIME_NS = 20;
  localparam int WIDE_ENTER_CYC_RAW = WIDE_ENTER_TIME_NS / CLK_PERIOD_NS;
  localparam int WIDE_EXIT_CYC_RAW = WIDE_EXIT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [3:0] WIDE_ENTER_CYC = 4'(WIDE_ENTER_CYC_RAW < 1 ? 1 : WIDE_ENTER_CYC_RAW);
  localparam logic [3:0] WIDE_EXIT_CYC = 4'(WIDE_EXIT_CYC_RAW < 1 ? 1 : WIDE_EXIT_CYC_RAW);

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SFCR_OP_NV_WREN,
    SFCR_OP_V_WREN,
    SFCR_OP_WRITE,
    SFCR_OP_NIB_ENTER,
    SFCR_OP_NIB_EXIT,
    SFCR_OP_SOFT_RESET
  } sfcr_op_type;

  typedef struct packed {
    sfcr_op_type op;
    logic [23:0] addr;
    logic [7:0] data;
  } sfcr_req_type;

  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] cfg2;
  } sfcr_snap_type;

endpackage

// >>> src/sfcr_regs.sv
// Purpose: Configuration register bank of a serial NOR flash behind its SPI pins
// Assumes: i_suspended, i_region_locks, i_status_guard, i_nvcfg1 come from logic on i_ref_clk
// Notes:   Link logic runs on i_sck; commands cross by toggle, snapshots by toggle handshake
`timescale 1ns/1ns
module sfcr_regs
  import sfcr_pkg::*;
(
  // Core clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Link pins
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_io0_si,
  input wire logic i_io2_wp_n,
  input wire logic i_io3,
  output logic o_so,
  output logic o_so_oe,
  // Device core status
  input wire logic i_suspended,
  input wire logic [3:0] i_region_locks,
  input wire logic i_status_guard,
  input wire logic [7:0] i_nvcfg1,
  // Live controls
  output logic o_quad_active,
  output logic o_wp_n_eff,
  output logic o_invert_map,
  output logic o_line3_reset_en,
  output logic [1:0] o_drive_strength,
  output logic o_nibble_cmd,
  output logic o_protect_scheme,
  output logic o_addr4,
  output logic o_register_freeze
);

  localparam int A_ENTER = WIDE_ENTER_CYC_RAW + 2;

  // ------------------------------------------------------------
  // Link domain: frame decode
  // ------------------------------------------------------------
  logic [5:0] bit_cnt_reg;
  logic [39:0] shift_reg;
  logic [39:0] shift_next;
  logic [7:0] cmd_reg;
  sfcr_req_type req_reg;
  sfcr_req_type req_next;
  logic req_tgl_reg;
  logic issue;

  assign shift_next = {shift_reg[38:0], i_io0_si};

  // Only IO0 is sampled here; IO2/IO3 reach the core only as write protect and reset
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      bit_cnt_reg <= 6'h00;
      shift_reg <= 40'h0000000000;
      cmd_reg <= 8'h00;
    end else begin
      shift_reg <= shift_next;
      if (bit_cnt_reg != BIT_SATURATE) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
      if (bit_cnt_reg == BIT_CMD_LAST) begin
        cmd_reg <= shift_next[7:0];
      end
    end
  end

  always_comb begin
    issue = 1'b0;
    req_next = req_reg;
    if (bit_cnt_reg == BIT_CMD_LAST) begin
      issue = 1'b1;
      req_next.addr = 24'h000000;
      req_next.data = 8'h00;
      unique case (shift_next[7:0])
        CMD_NV_WRITE_ENABLE: req_next.op = SFCR_OP_NV_WREN;
        CMD_VOLATILE_WRITE_ENABLE: req_next.op = SFCR_OP_V_WREN;
        CMD_NIBBLE_CMD_ENTER: req_next.op = SFCR_OP_NIB_ENTER;
        CMD_NIBBLE_CMD_EXIT: req_next.op = SFCR_OP_NIB_EXIT;
        CMD_SOFT_RESET: req_next.op = SFCR_OP_SOFT_RESET;
        default: issue = 1'b0;
      endcase
    end else if (bit_cnt_reg == BIT_WRITE_REGS_LAST && cmd_reg == CMD_WRITE_REGS) begin
      // Second data byte of the two-byte register write lands in config one
      issue = 1'b1;
      req_next.op = SFCR_OP_WRITE;
      req_next.addr = ADDR_VOLATILE_CONFIG_ONE;
      req_next.data = shift_next[7:0];
    end else if (bit_cnt_reg == BIT_WRITE_ANY_LAST && cmd_reg == CMD_WRITE_ANY_REG) begin
      issue = 1'b1;
      req_next.op = SFCR_OP_WRITE;
      req_next.addr = shift_next[31:8];
      req_next.data = shift_next[7:0];
    end
  end

  // Payload held until the next command so the core can sample it safely
  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst) begin
      req_reg <= '0;
      req_tgl_reg <= 1'b0;
    end else if (issue) begin
      req_reg <= req_next;
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  // ------------------------------------------------------------
  // Link domain: register snapshot receive
  // ------------------------------------------------------------
  sfcr_snap_type snap_reg;
  logic snap_tgl_reg;
  logic snap_sync1_reg;
  logic snap_sync2_reg;
  logic snap_ack_reg;
  sfcr_snap_type link_copy_reg;

  // Limitation: updates land only while the host clocks the link
  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst) begin
      snap_sync1_reg <= 1'b0;
      snap_sync2_reg <= 1'b0;
      snap_ack_reg <= 1'b0;
      link_copy_reg <= '0;
    end else begin
      snap_sync1_reg <= snap_tgl_reg;
      snap_sync2_reg <= snap_sync1_reg;
      if (snap_sync2_reg != snap_ack_reg) begin
        link_copy_reg <= snap_reg;
        snap_ack_reg <= ~snap_ack_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // Link domain: read data out on falling edge
  // ------------------------------------------------------------
  logic [7:0] out_byte_reg;
  logic [7:0] out_sh_reg;
  logic [2:0] out_idx_reg;
  logic [7:0] any_byte;

  always_comb begin
    unique case (shift_reg[23:0])
      ADDR_VOLATILE_CONFIG_ONE: any_byte = link_copy_reg.cfg1;
      ADDR_NONVOLATILE_CONFIG_TWO: any_byte = link_copy_reg.cfg2;
      default: any_byte = 8'h00;
    endcase
  end

  always_ff @(negedge i_sck or posedge i_cs_n or posedge i_rst) begin
    if (i_rst || i_cs_n) begin
      out_byte_reg <= 8'h00;
      out_sh_reg <= 8'h00;
      out_idx_reg <= 3'h0;
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
    end else if (!o_so_oe && bit_cnt_reg == BIT_READ_ONE_OUT && cmd_reg == CMD_READ_CONFIG_ONE) begin
      out_byte_reg <= link_copy_reg.cfg1;
      out_sh_reg <= {link_copy_reg.cfg1[6:0], 1'b0};
      o_so <= link_copy_reg.cfg1[7];
      out_idx_reg <= 3'h7;
      o_so_oe <= 1'b1;
    end else if (!o_so_oe && bit_cnt_reg == BIT_READ_ANY_OUT && cmd_reg == CMD_READ_ANY_REG) begin
      out_byte_reg <= any_byte;
      out_sh_reg <= {any_byte[6:0], 1'b0};
      o_so <= any_byte[7];
      out_idx_reg <= 3'h7;
      o_so_oe <= 1'b1;
    end else if (o_so_oe) begin
      // Byte repeats until the host deselects; index 0 means bit 0 is on the pin
      if (out_idx_reg == 3'h0) begin
        out_sh_reg <= {out_byte_reg[6:0], 1'b0};
      end else begin
        out_sh_reg <= {out_sh_reg[6:0], 1'b0};
      end
      o_so <= (out_idx_reg == 3'h0) ? out_byte_reg[7] : out_sh_reg[7];
      out_idx_reg <= out_idx_reg - 3'h1;
    end
  end

  // ------------------------------------------------------------
  // Core domain: pin and request synchronisers
  // ------------------------------------------------------------
  logic [2:0] req_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] wp_sync_reg;
  logic [1:0] io3_sync_reg;
  logic req_ev;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      req_sync_reg <= 3'h0;
      cs_sync_reg <= 2'h3;
      wp_sync_reg <= 2'h3;
      io3_sync_reg <= 2'h3;
    end else begin
      req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
      cs_sync_reg <= {cs_sync_reg[0], i_cs_n};
      wp_sync_reg <= {wp_sync_reg[0], i_io2_wp_n};
      io3_sync_reg <= {io3_sync_reg[0], i_io3};
    end
  end

  assign req_ev = req_sync_reg[2] ^ req_sync_reg[1];

  // ------------------------------------------------------------
  // Core domain: resets and write permission
  // ------------------------------------------------------------
  logic boot_reg;
  logic hw_reset;
  logic reload;
  logic soft_load;
  logic wide_target;
  logic wp_n_int;
  logic locked;
  logic wr_ev;
  logic wel_v_reg;
  logic wel_nv_reg;
  logic wr_cfg1;
  logic wr_cfg2;

  logic inv_map_reg;
  logic wide_reg;
  logic freeze_reg;
  logic nib_reg;
  logic halt_reg;
  logic [3:0] locks_reg;
  logic [7:0] cfg2nv_reg;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end

  // IO3 acts as reset while deselected, or while selected unless both wide width and nibble mode are set
  assign hw_reset = o_line3_reset_en && !io3_sync_reg[1]
    && (cs_sync_reg[1] || !wide_reg || !nib_reg);
  assign reload = boot_reg || hw_reset;
  assign soft_load = reload || (req_ev && req_reg.op == SFCR_OP_SOFT_RESET);
  assign wide_target = wide_reg || nib_reg;
  // Four-wire protocol also means four-bit width, so the pin is a data line then too
  assign wp_n_int = wide_target ? 1'b1 : wp_sync_reg[1];
  assign locked = freeze_reg || (i_status_guard && !wp_n_int);
  assign wr_ev = req_ev && req_reg.op == SFCR_OP_WRITE;
  assign wr_cfg1 = wr_ev && wel_v_reg && !locked && req_reg.addr == ADDR_VOLATILE_CONFIG_ONE;
  assign wr_cfg2 = wr_ev && wel_nv_reg && !locked && req_reg.addr == ADDR_NONVOLATILE_CONFIG_TWO;

  // Any write attempt consumes the enable, accepted or not
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wel_v_reg <= 1'b0;
      wel_nv_reg <= 1'b0;
    end else if (soft_load || wr_ev) begin
      wel_v_reg <= 1'b0;
      wel_nv_reg <= 1'b0;
    end else if (req_ev && req_reg.op == SFCR_OP_NV_WREN) begin
      wel_v_reg <= 1'b1;
      wel_nv_reg <= 1'b1;
    end else if (req_ev && req_reg.op == SFCR_OP_V_WREN) begin
      wel_v_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Core domain: volatile config one
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      halt_reg <= 1'b0;
      locks_reg <= 4'h0;
    end else begin
      halt_reg <= i_suspended;
      locks_reg <= i_region_locks;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      inv_map_reg <= 1'b0;
      wide_reg <= 1'b0;
    end else if (soft_load) begin
      inv_map_reg <= i_nvcfg1[CFG1_INVERT_BIT];
      wide_reg <= i_nvcfg1[CFG1_WIDE_BIT];
    end else if (wr_cfg1) begin
      inv_map_reg <= req_reg.data[CFG1_INVERT_BIT];
      wide_reg <= req_reg.data[CFG1_WIDE_BIT];
    end
  end

  // Software reset leaves the lock alone; a write can only set it, a hardware reset reloads it from i_nvcfg1
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      freeze_reg <= 1'b0;
    end else if (reload) begin
      freeze_reg <= i_nvcfg1[CFG1_FREEZE_BIT];
    end else if (wr_cfg1) begin
      freeze_reg <= freeze_reg | req_reg.data[CFG1_FREEZE_BIT];
    end
  end

  // ------------------------------------------------------------
  // Core domain: config two, stored and live
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg2nv_reg <= CFG2_NV_RESET;
    end else if (wr_cfg2) begin
      cfg2nv_reg <= req_reg.data & CFG2_WRITE_MASK;
    end
  end

  // Stored copy only takes effect at the next reset
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_line3_reset_en <= 1'b0;
      o_drive_strength <= 2'h3;
      o_protect_scheme <= 1'b0;
      o_addr4 <= 1'b0;
    end else if (soft_load) begin
      o_line3_reset_en <= cfg2nv_reg[CFG2_LINE3_RESET_BIT];
      o_drive_strength <= cfg2nv_reg[CFG2_DRIVE_HI_BIT:CFG2_DRIVE_LO_BIT];
      o_protect_scheme <= cfg2nv_reg[CFG2_PROTECT_BIT];
      o_addr4 <= cfg2nv_reg[CFG2_ADDR_LEN_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      nib_reg <= 1'b0;
    end else if (soft_load) begin
      nib_reg <= cfg2nv_reg[CFG2_NIBBLE_BIT];
    end else if (req_ev && req_reg.op == SFCR_OP_NIB_ENTER) begin
      nib_reg <= 1'b1;
    end else if (req_ev && req_reg.op == SFCR_OP_NIB_EXIT) begin
      nib_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Core domain: width switch timing and outputs
  // ------------------------------------------------------------
  logic [3:0] switch_cnt_reg;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      switch_cnt_reg <= 4'h0;
      o_quad_active <= 1'b0;
    end else if (wide_target == o_quad_active) begin
      switch_cnt_reg <= 4'h0;
    end else if (switch_cnt_reg + 4'h1 >= (wide_target ? WIDE_ENTER_CYC : WIDE_EXIT_CYC)) begin
      switch_cnt_reg <= 4'h0;
      o_quad_active <= wide_target;
    end else begin
      switch_cnt_reg <= switch_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wp_n_eff <= 1'b1;
      o_invert_map <= 1'b0;
      o_nibble_cmd <= 1'b0;
      o_register_freeze <= 1'b0;
    end else begin
      o_wp_n_eff <= wp_n_int;
      o_invert_map <= inv_map_reg;
      o_nibble_cmd <= nib_reg;
      o_register_freeze <= freeze_reg;
    end
  end

  // ------------------------------------------------------------
  // Core domain: snapshot send
  // ------------------------------------------------------------
  sfcr_snap_type live_snap;
  logic [1:0] ack_sync_reg;

  assign live_snap.cfg1 = {halt_reg, inv_map_reg, locks_reg, wide_reg, freeze_reg};
  assign live_snap.cfg2 = cfg2nv_reg;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_sync_reg <= 2'h0;
      snap_reg <= '0;
      snap_tgl_reg <= 1'b0;
    end else begin
      ack_sync_reg <= {ack_sync_reg[0], snap_ack_reg};
      if (ack_sync_reg[1] == snap_tgl_reg && live_snap != snap_reg) begin
        snap_reg <= live_snap;
        snap_tgl_reg <= ~snap_tgl_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_halt_read_only: assert property (!$past(i_rst) |-> live_snap.cfg1[7] == $past(i_suspended))
    else $error("suspend bit does not follow core status");
  a_invert_write: assert property (wr_cfg1 && !soft_load |=> inv_map_reg == $past(req_reg.data[6]))
    else $error("invert map bit not written");
  a_lock_copies: assert property (!$past(i_rst) |-> live_snap.cfg1[5:2] == $past(i_region_locks))
    else $error("region lock copies stale");
  a_wp_ignored: assert property (wide_target |=> o_wp_n_eff)
    else $error("write protect seen in quad width");
  a_quad_settle: assert property ($rose(wide_target) |-> ##[1:A_ENTER] (o_quad_active || !wide_target))
    else $error("quad entry too slow");
  a_nibble_wide: assert property (nib_reg[*8] |-> o_quad_active)
    else $error("four-wire protocol without four-bit width");
  a_freeze_blocks: assert property (freeze_reg && wr_ev && !soft_load
    |=> $stable(inv_map_reg) && $stable(wide_reg) && $stable(cfg2nv_reg))
    else $error("write accepted while locked");
  a_guard_blocks: assert property (wr_ev && i_status_guard && !wp_n_int && !soft_load
    |=> $stable(inv_map_reg) && $stable(cfg2nv_reg))
    else $error("write accepted under status guard");
  a_freeze_sticky: assert property (freeze_reg && !reload |=> freeze_reg)
    else $error("register lock cleared without hardware reset");
  a_cfg2_reserved: assert property (cfg2nv_reg[4] == 1'b0 && cfg2nv_reg[0] == 1'b0)
    else $error("reserved config two bit set");

endmodule

// >>> bench/sfcr_host.sv
// Purpose: Host SPI controller model that issues register commands
// Assumes: Mode 0, link clock of 64 ns that stands low outside frames
// Notes:   Single-wire commands only; the last captured byte is the read result
`timescale 1ns/1ns
module sfcr_host (
  // Link pins
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so,
  // Read result
  output logic [7:0] o_rd,
  output logic o_rd_done
);
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b1;
    o_rd = 8'h00;
    o_rd_done = 1'b0;
  end
  // Never sends quad reads, so the quad bit is never a precondition here
  // Odd start offset keeps the link edges off the core edges for frames that start on a core edge
  task automatic frame(input logic [47:0] bits, input int n, input logic rd);
    #3 o_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_si = bits[i];
      #32 o_sck = 1'b1;
      o_rd = {o_rd[6:0], i_so};
      #32 o_sck = 1'b0;
    end
    #32 o_cs_n = 1'b1;
    o_si = ~o_si;
    o_rd_done = rd;
    #128 o_rd_done = 1'b0;
  endtask
endmodule

// >>> bench/testbench.sv
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Host model drives the link; core inputs driven at the rising edge, except i_region_locks and one i_nvcfg1 change at the falling edge
// Notes:   Expected read values are queued by the driver and compared by a watcher
`timescale 1ns/1ns
module testbench;
  import sfcr_pkg::*;
  logic i_ref_clk, i_rst, i_io2_wp_n, i_io3, i_suspended, i_status_guard;
  logic [3:0] i_region_locks;
  logic [7:0] i_nvcfg1, rd_data;
  logic sck, cs_n, si, so, rd_done, qa, wpe, inv, l3, nib, prot, a4, frz, soe, oe_seen;
  logic [1:0] drv;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int total_checks = 0;

  sfcr_regs sfcr_regs_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n), .i_io0_si(si),
    .i_io2_wp_n(i_io2_wp_n), .i_io3(i_io3), .o_so(so), .o_so_oe(soe), .i_suspended(i_suspended),
    .i_region_locks(i_region_locks), .i_status_guard(i_status_guard), .i_nvcfg1(i_nvcfg1),
    .o_quad_active(qa), .o_wp_n_eff(wpe), .o_invert_map(inv), .o_line3_reset_en(l3), .o_drive_strength(drv),
    .o_nibble_cmd(nib), .o_protect_scheme(prot), .o_addr4(a4), .o_register_freeze(frz));
  sfcr_host sfcr_host_i (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .o_rd(rd_data), .o_rd_done(rd_done));

  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    total_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge i_ref_clk) i_rst <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
  endtask
  task automatic cmd(input logic [47:0] b, input int n);
    sfcr_host_i.frame(b, n, 1'b0);
  endtask
  task automatic wr(input logic [7:0] en, input logic [23:0] a, input logic [7:0] d);
    cmd({40'h0, en}, 8);
    cmd({8'h00, CMD_WRITE_ANY_REG, a, d}, 40);
  endtask
  // Address of all ones selects the dedicated config one read
  task automatic rd(input logic [23:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    if (a == 24'hFFFFFF) begin
      sfcr_host_i.frame({32'h0, CMD_READ_CONFIG_ONE, 8'h00}, 16, 1'b1);
    end else begin
      sfcr_host_i.frame({8'h00, CMD_READ_ANY_REG, a, 8'h00}, 40, 1'b1);
    end
  endtask
  function automatic logic [7:0] c1(input logic iv, input logic q, input logic l);
    return {i_suspended, iv, i_region_locks, q, l};
  endfunction
  // Order: quad, wp, invert, line3, drive, nibble, scheme, addr4, freeze
  task automatic live(input logic [9:0] want);
    repeat (12) @(negedge i_ref_clk);
    check({qa, wpe, inv, l3, drv, nib, prot, a4, frz}, want);
  endtask

  // Output enable as the host saw it at the last bit of the frame
  always @(posedge sck) oe_seen <= soe;
  always @(posedge rd_done) begin
    check({2'b00, rd_data}, {2'b00, exp_q.pop_front()});
    check({9'h000, oe_seen}, 10'h001);
  end

  initial begin
    #300000;
    num_errors++;
    final_report();
  end

  initial begin
    i_rst = 1'b1;
    i_io2_wp_n = 1'b0;
    i_io3 = 1'b1;
    i_status_guard = 1'b0;
    i_nvcfg1 = 8'h40;
    void'($urandom(32'hC87A382A));
    i_suspended = 1'($urandom);
    i_region_locks = 4'($urandom);
    do_reset();
    live(10'b0010110000);
    rd(24'hFFFFFF, c1(1'b1, 1'b0, 1'b0));
    rd(ADDR_NONVOLATILE_CONFIG_TWO, 8'h60);
    rd(24'h000010, 8'h00);
    $display("test 1 done");
    wr(8'h00, ADDR_VOLATILE_CONFIG_ONE, 8'hFF);
    rd(24'hFFFFFF, c1(1'b1, 1'b0, 1'b0));
    wr(CMD_VOLATILE_WRITE_ENABLE, ADDR_VOLATILE_CONFIG_ONE, 8'hBE);
    @(posedge i_ref_clk) i_io2_wp_n <= 1'($urandom);
    live(10'b1100110000);
    i_region_locks <= 4'($urandom);
    repeat (4) @(posedge i_ref_clk);
    rd(24'hFFFFFF, c1(1'b0, 1'b1, 1'b0));
    $display("test 2 done");
    cmd({40'h0, CMD_VOLATILE_WRITE_ENABLE}, 8);
    cmd({24'h0, CMD_WRITE_REGS, 8'h00, 8'h40}, 24);
    @(posedge i_ref_clk) i_io2_wp_n <= 1'b0;
    live(10'b0010110000);
    @(posedge i_ref_clk) i_status_guard <= 1'b1;
    wr(CMD_VOLATILE_WRITE_ENABLE, ADDR_VOLATILE_CONFIG_ONE, 8'h00);
    rd(24'hFFFFFF, c1(1'b1, 1'b0, 1'b0));
    @(posedge i_ref_clk) i_status_guard <= 1'b0;
    $display("test 3 done");
    wr(CMD_NV_WRITE_ENABLE, ADDR_NONVOLATILE_CONFIG_TWO, 8'h9F);
    rd(ADDR_NONVOLATILE_CONFIG_TWO, 8'h8E);
    live(10'b0010110000);
    cmd({40'h0, CMD_SOFT_RESET}, 8);
    live(10'b1111001110);
    $display("test 4 done");
    wr(CMD_VOLATILE_WRITE_ENABLE, ADDR_VOLATILE_CONFIG_ONE, 8'h03);
    rd(24'hFFFFFF, c1(1'b0, 1'b1, 1'b1));
    wr(CMD_VOLATILE_WRITE_ENABLE, ADDR_VOLATILE_CONFIG_ONE, 8'h00);
    rd(24'hFFFFFF, c1(1'b0, 1'b1, 1'b1));
    cmd({40'h0, CMD_SOFT_RESET}, 8);
    live(10'b1111001111);
    $display("test 5 done");
    @(posedge i_ref_clk) i_nvcfg1 <= 8'h00;
    i_io3 <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    i_io3 <= 1'b1;
    live(10'b1101001110);
    $display("test 6 done");
    i_nvcfg1 <= 8'h03;
    do_reset();
    live(10'b1100110001);
    rd(ADDR_NONVOLATILE_CONFIG_TWO, 8'h60);
    rd(ADDR_VOLATILE_CONFIG_ONE, c1(1'b0, 1'b1, 1'b1));
    cmd({40'h0, CMD_NIBBLE_CMD_ENTER}, 8);
    live(10'b1100111001);
    cmd({40'h0, CMD_NIBBLE_CMD_EXIT}, 8);
    live(10'b1100110001);
    $display("test 7 done");
    final_report();
  end
endmodule
